// ---- logic/sac_pkg.sv ----
// Shared constants for the successive-approximation converter control block
package sac_pkg;

  // ********************************************************
  // Register indices; byte address is four times the index
  // ********************************************************
  localparam logic [7:0] IDX_CTRL_ONE = 8'h0e;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h0f;
  localparam logic [7:0] IDX_RESULT = 8'h10;
  localparam logic [7:0] IDX_STATE = 8'h11;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h12;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h13;
  localparam int ADDR_LSB = 2;

  // ********************************************************
  // Field positions and reset values
  // ********************************************************
  localparam int C1_START = 7;
  localparam int C1_MODE_HI = 6;
  localparam int C1_MODE_LO = 5;
  localparam int C1_GATE = 4;
  localparam int C1_CHAN_HI = 3;
  localparam logic [7:0] C1_RESET = 8'h10;
  localparam int C2_LADDER = 5;
  localparam int C2_ONE = 4;
  localparam int C2_TIME_HI = 3;
  localparam int C2_TIME_LO = 1;
  localparam logic [2:0] C2_TIME_RESET = 3'h0;
  localparam int ST_DONE = 7;
  localparam int ST_BUSY = 6;
  localparam int IRQ_DONE = 0;

  // ********************************************************
  // Operating modes and channel range
  // ********************************************************
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_SOFT = 2'h1,
    MODE_RSVD = 2'h2,
    MODE_REPEAT = 2'h3
  } sac_mode_t;
  localparam int RES_BITS = 10;
  localparam int NUM_CHANNELS = 8;

  // ********************************************************
  // Conversion timing: 13 equal steps of 3 << k clocks
  // ********************************************************
  localparam int STEP_BASE = 3;
  localparam int SAMPLE_STEPS = 2;
  localparam int STEP_W = 8;
  localparam int CONV_STEPS = SAMPLE_STEPS + RES_BITS + 1;

endpackage

// ---- logic/sac_sar_engine.sv ----
// Successive-approximation sequencer: sample, bit search, finish
`timescale 1ns/1ps
module sac_sar_engine import sac_pkg::*; #(
  parameter int RES_W = RES_BITS,
  parameter int CNT_W = STEP_W
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic start, // Launch pulse
  input wire logic [CNT_W-1:0] step_len, // Clocks per step
  input wire logic comp_hi, // Held input at or above ladder
  output logic busy, // Conversion running
  output logic sample_q, // Sample-hold tracking
  output logic [RES_W-1:0] trial_q, // Ladder code
  output logic done_q, // One-cycle completion pulse
  output logic [RES_W-1:0] result_q // Last finished code
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SAMPLE = 2'b01,
    S_BITS = 2'b11,
    S_DONE = 2'b10
  } sac_sar_state_t;

  sac_sar_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] step_q;
  logic [RES_W-1:0] ptr_q;
  logic tick;
  logic last_step;

  // Step timing shared by every phase
  assign tick = (cnt_q == step_len - 1'b1);
  assign last_step = (st_q == S_SAMPLE) ? (step_q == 4'(SAMPLE_STEPS - 1)) :
                     (st_q == S_BITS) ? ptr_q[0] : 1'b1;
  assign busy = (st_q != S_IDLE);

  // Phase sequencing
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: if (start) st_d = S_SAMPLE;
      S_SAMPLE: if (tick && last_step) st_d = S_BITS;
      S_BITS: if (tick && last_step) st_d = S_DONE;
      S_DONE: if (tick) st_d = S_IDLE;
    endcase
  end

  // Cycle counter restarts on each step boundary; step counter on each phase change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      step_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= (!busy || tick) ? '0 : cnt_q + 1'b1;
      step_q <= (st_d != st_q) ? '0 : (tick ? step_q + 1'b1 : step_q);
    end
  end

  // One bit decided per step, MSB first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= '0;
      trial_q <= '0;
      sample_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= '0;
    end else begin
      sample_q <= (st_d == S_SAMPLE);
      done_q <= (st_q == S_DONE) && tick;
      if (st_q == S_IDLE && start) begin
        ptr_q <= {1'b1, {(RES_W-1){1'b0}}};
        trial_q <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (st_q == S_BITS && tick) begin
        ptr_q <= ptr_q >> 1;
        trial_q <= (comp_hi ? trial_q : (trial_q & ~ptr_q)) | (ptr_q >> 1);
      end
      if (st_q == S_DONE && tick) result_q <= trial_q;
    end
  end

endmodule // sac_sar_engine

// ---- logic/sac_adc_ctrl.sv ----
// Converter control top: AHB-Lite registers, launch logic, interrupt
// Overview of operation
// - Each sample resolves to a 10-bit code, one bit per step from the MSB down.
// - The held input is compared against the ladder and the trial code follows each decision.
// - Control register one holds start in bit 7, mode in bits 6:5, input gate in 4, channel in 3:0.
// - Writing one to the start bit launches a conversion in modes 01 and 11 with channel 0 to 7; writing zero does nothing.
// - Mode 00 disables, 01 is software start, 10 is reserved, 11 is repeat.
// - Control register two selects conversion time and whether the ladder stays connected.
// - A finished code is placed in the result register for software.
// - The state register shows completion and whether a conversion is running.
// - The start bit clears itself one cycle after it is set, whether or not a conversion launches.
// - Channel codes 0 to 7 pick an input; higher codes are reserved.
`timescale 1ns/1ps
module sac_adc_ctrl import sac_pkg::*; #(
  parameter int RES_W = RES_BITS
) (
  input wire logic clock, // 250 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout_q, // Slave ready
  output logic hresp_q, // Always OKAY
  output logic [31:0] hrdata_q, // Read data
  input wire logic comp_hi, // Comparator decision
  output logic [2:0] chan_sel_q, // Analog input mux select
  output logic input_gate_q, // High disables analog inputs
  output logic sample_hold_q, // Sample-hold tracking
  output logic [RES_W-1:0] dac_code_q, // Ladder code
  output logic ladder_on_q, // Ladder connected
  output logic conv_irq_q // Level interrupt
);

  // ********************************************************
  // Bus capture
  // ********************************************************
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] idx_q;
  logic take;
  logic take_ok;

  // Only whole-word writes reach the registers; reads of any size are answered
  assign take = hsel && htrans[1] && hready;
  assign take_ok = take && (hsize == 3'h2);

  // Reads take one wait state so a write just before is visible
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= '0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= take_ok && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take) idx_q <= haddr[ADDR_LSB+7:ADDR_LSB];
      hreadyout_q <= !(take && !hwrite);
      hresp_q <= 1'b0;
    end
  end

  // ********************************************************
  // Write decode
  // ********************************************************
  logic wr_c1;
  logic wr_c2;
  logic wr_istat;
  logic wr_imask;
  logic rd_result;
  logic [7:0] wbyte;

  assign wbyte = hwdata[7:0];
  assign wr_c1 = wr_pend_q && (idx_q == IDX_CTRL_ONE);
  assign wr_c2 = wr_pend_q && (idx_q == IDX_CTRL_TWO);
  assign wr_istat = wr_pend_q && (idx_q == IDX_IRQ_STAT);
  assign wr_imask = wr_pend_q && (idx_q == IDX_IRQ_MASK);
  assign rd_result = rd_pend_q && (idx_q == IDX_RESULT);

  // ********************************************************
  // Control registers
  // ********************************************************
  sac_mode_t mode_q;
  logic start_q;
  logic [3:0] chan_q;
  logic ladder_keep_q;
  logic [2:0] ctime_q;

  // Control one fields; start is a one-cycle request, cleared whether or not it launches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= C1_RESET[C1_START];
      mode_q <= sac_mode_t'(C1_RESET[C1_MODE_HI:C1_MODE_LO]);
      input_gate_q <= C1_RESET[C1_GATE];
      chan_q <= C1_RESET[C1_CHAN_HI:0];
    end else if (wr_c1) begin
      start_q <= wbyte[C1_START] || start_q;
      mode_q <= sac_mode_t'(wbyte[C1_MODE_HI:C1_MODE_LO]);
      input_gate_q <= wbyte[C1_GATE];
      chan_q <= wbyte[C1_CHAN_HI:0];
    end else if (start_q) begin
      start_q <= 1'b0;
    end
  end

  // Control two: ladder policy and conversion time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ladder_keep_q <= 1'b0;
      ctime_q <= C2_TIME_RESET;
    end else if (wr_c2) begin
      ladder_keep_q <= wbyte[C2_LADDER];
      ctime_q <= wbyte[C2_TIME_HI:C2_TIME_LO];
    end
  end

  // ********************************************************
  // Launch logic
  // ********************************************************
  logic mode_run;
  logic chan_ok;
  logic launch;
  logic relaunch;
  logic [STEP_W-1:0] step_len;
  logic eng_busy;
  logic eng_done;
  logic eng_sample;
  logic [RES_W-1:0] eng_trial;
  logic [RES_W-1:0] eng_result;

  // Reserved mode and reserved channels never start the engine
  assign mode_run = (mode_q == MODE_SOFT) || (mode_q == MODE_REPEAT);
  assign chan_ok = (chan_q < 4'(NUM_CHANNELS));
  assign relaunch = eng_done && (mode_q == MODE_REPEAT);
  assign launch = (start_q || relaunch) && mode_run && chan_ok;

  // Time code to step length; reserved codes take the slowest setting
  always_comb begin
    unique case (ctime_q)
      3'h0: step_len = STEP_W'(STEP_BASE);
      3'h2: step_len = STEP_W'(STEP_BASE << 1);
      3'h3: step_len = STEP_W'(STEP_BASE << 2);
      3'h4: step_len = STEP_W'(STEP_BASE << 3);
      3'h5: step_len = STEP_W'(STEP_BASE << 4);
      default: step_len = STEP_W'(STEP_BASE << 5);
    endcase
  end

  // Engine ignores a start while running; a repeat relaunch comes with the done pulse, once it is idle
  sac_sar_engine #(
    .RES_W(RES_W),
    .CNT_W(STEP_W)
  ) u_engine (
    .clock(clock),
    .rst_n(rst_n),
    .start(launch),
    .step_len(step_len),
    .comp_hi(comp_hi),
    .busy(eng_busy),
    .sample_q(eng_sample),
    .trial_q(eng_trial),
    .done_q(eng_done),
    .result_q(eng_result)
  );

  // ********************************************************
  // Analog-side outputs
  // ********************************************************
  logic conv_active_q;

  // Channel only changes between conversions to keep the held value clean
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chan_sel_q <= '0;
      sample_hold_q <= 1'b0;
      dac_code_q <= '0;
      ladder_on_q <= 1'b0;
      conv_active_q <= 1'b0;
    end else begin
      if (!eng_busy) chan_sel_q <= chan_q[2:0];
      sample_hold_q <= eng_sample;
      dac_code_q <= eng_trial;
      conv_active_q <= eng_busy || launch;
      ladder_on_q <= ladder_keep_q || eng_busy || launch;
    end
  end

  // ********************************************************
  // Completion flag and interrupt
  // ********************************************************
  logic done_flag_q;
  logic irq_stat_q;
  logic irq_mask_q;

  // Set wins over read-clear and write-one-clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_flag_q <= 1'b0;
      irq_stat_q <= 1'b0;
      irq_mask_q <= 1'b0;
      conv_irq_q <= 1'b0;
    end else begin
      done_flag_q <= eng_done || (done_flag_q && !rd_result);
      irq_stat_q <= eng_done || (irq_stat_q && !(wr_istat && wbyte[IRQ_DONE]));
      if (wr_imask) irq_mask_q <= wbyte[IRQ_DONE];
      conv_irq_q <= irq_stat_q && irq_mask_q;
    end
  end

  // ********************************************************
  // Read mux
  // ********************************************************
  logic [7:0] c1_rd;
  logic [7:0] c2_rd;
  logic [7:0] st_rd;
  logic [31:0] rd_mux;

  // Start bit always reads back as zero once launched
  assign c1_rd = {start_q, mode_q, input_gate_q, chan_q};
  assign c2_rd = {2'h0, ladder_keep_q, 1'b1, ctime_q, 1'b0};
  assign st_rd = {done_flag_q, conv_active_q, 6'h0};

  always_comb begin
    unique case (idx_q)
      IDX_CTRL_ONE: rd_mux = {24'h0, c1_rd};
      IDX_CTRL_TWO: rd_mux = {24'h0, c2_rd};
      IDX_RESULT: rd_mux = {{(32-RES_W){1'b0}}, eng_result};
      IDX_STATE: rd_mux = {24'h0, st_rd};
      IDX_IRQ_STAT: rd_mux = {31'h0, irq_stat_q};
      IDX_IRQ_MASK: rd_mux = {31'h0, irq_mask_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // Data stands until the next read answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

endmodule // sac_adc_ctrl

// ---- testbench/sac_adc_ctrl_chk.sv ----
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module sac_adc_ctrl_chk import sac_pkg::*; #(
  parameter int RES_W = RES_BITS
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Async reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic hreadyout_q, // Slave ready
  input wire logic hresp_q, // Response
  input wire logic [31:0] hrdata_q, // Read data
  input wire logic comp_hi, // Comparator
  input wire logic [2:0] chan_sel_q, // Mux select
  input wire logic input_gate_q, // Input gate
  input wire logic sample_hold_q, // Sample phase
  input wire logic [RES_W-1:0] dac_code_q, // Ladder code
  input wire logic ladder_on_q, // Ladder on
  input wire logic conv_irq_q // Interrupt
);
  // ****************************************
  // Bus phase tracking
  // ****************************************
  logic wr_q;
  logic c1_q;
  wire logic taken = hsel && htrans[1] && hready;
  wire logic wr_c1 = wr_q && c1_q;
  // Data phase of a write, and whether it hit control one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      c1_q <= 1'b0;
    end else begin
      wr_q <= taken && hwrite;
      c1_q <= haddr[9:2] == IDX_CTRL_ONE;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_rd_req;
    taken && !hwrite;
  endsequence
  sequence s_rd_ans;
    !hreadyout_q ##1 hreadyout_q;
  endsequence
  a_resp_okay: assert property (!hresp_q) else $error("error response seen");
  a_read_wait: assert property (s_rd_req |=> s_rd_ans) else $error("read answer timing wrong");
  a_write_fast: assert property (taken && hwrite |=> hreadyout_q) else $error("write stalled");
  a_launch_soft: assert property (wr_c1 && hwdata[7] && hwdata[5] && !hwdata[3] |-> ##[1:4] sample_hold_q)
    else $error("start did not launch");
  a_no_launch: assert property (wr_c1 && hwdata[7] && !hwdata[5] |=> !sample_hold_q [*4])
    else $error("disabled mode launched");
  a_sample_len: assert property ($rose(sample_hold_q) |=> sample_hold_q [*5]) else $error("sample too short");
  a_sample_ladder: assert property (sample_hold_q |-> ladder_on_q) else $error("ladder off while sampling");
  a_chan_hold: assert property (sample_hold_q |=> $stable(chan_sel_q)) else $error("channel moved in use");
  a_msb_first: assert property ($fell(sample_hold_q) |-> ##[0:2]
    (dac_code_q[RES_W-1] && dac_code_q[RES_W-2:0] == '0)) else $error("search not from top bit");
  a_irq_drop: assert property ($fell(conv_irq_q) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("interrupt dropped without write");
endmodule // sac_adc_ctrl_chk

bind sac_adc_ctrl sac_adc_ctrl_chk #(.RES_W(RES_W)) u_chk (
  .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
  .hrdata_q(hrdata_q), .comp_hi(comp_hi), .chan_sel_q(chan_sel_q), .input_gate_q(input_gate_q),
  .sample_hold_q(sample_hold_q), .dac_code_q(dac_code_q), .ladder_on_q(ladder_on_q), .conv_irq_q(conv_irq_q)
);

// ---- testbench/testbench.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench import sac_pkg::*;;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic comp_hi = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic hready, hresp, irq, gate, sh, lad;
  wire logic [31:0] hrdata;
  wire logic [2:0] chan;
  wire logic [9:0] dac;
  int mismatches = 0;
  int checked = 0;

  always #2 clock = ~clock;
  // Analog level differs per channel, so a wrong mux shows in the code
  always @(posedge clock) comp_hi <= {chan, 7'h35} >= dac;

  sac_adc_ctrl DUT (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout_q(hready),
    .hresp_q(hresp), .hrdata_q(hrdata), .comp_hi(comp_hi), .chan_sel_q(chan), .input_gate_q(gate),
    .sample_hold_q(sh), .dac_code_q(dac), .ladder_on_q(lad), .conv_irq_q(irq));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    $display("[ERR] %0t wait expired", $time);
    test_done();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clock);
  endtask
  // One word transfer; called just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n = 0;
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rd = hrdata;
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    do begin @(posedge clock); n++; end while (irq !== 1'b1 && n < 3000);
    if (n >= 3000) hang();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    bus(0, IDX_CTRL_ONE, 0);
    chk(rd, 32'h10);
    bus(0, IDX_CTRL_TWO, 0);
    chk(rd, 32'h10);
    bus(0, IDX_STATE, 0);
    chk(rd, 32'h0);
    bus(0, 8'h40, 0);
    chk(rd, 32'h0);
    chk(32'(gate), 32'h1);
  endtask
  // Every channel and time code; channel 5 keeps the ladder on
  task automatic t_soft();
    int n, len;
    logic [2:0] tc;
    bus(1, IDX_IRQ_MASK, 32'h1);
    for (int ch = 0; ch < 8; ch++) begin
      tc = 3'(ch);
      len = tc == 0 ? 3 : (tc == 1 || tc == 7) ? 96 : 3 << (tc - 1);
      bus(1, IDX_CTRL_TWO, {26'h0, ch == 5, 1'b0, tc, 1'b0});
      bus(0, IDX_CTRL_TWO, 0);
      chk(rd, {26'h0, ch == 5, 1'b1, tc, 1'b0});
      bus(1, IDX_CTRL_ONE, 32'ha0 | 32'(ch));
      bus(0, IDX_STATE, 0);
      chk(rd & 32'hc0, 32'h40);
      chk(32'(chan), 32'(ch));
      chk(32'(gate), 32'h0);
      wait_irq(n);
      chk(32'(n + 3 >= 13 * len && n + 3 <= 13 * len + 8), 32'h1);
      bus(0, IDX_STATE, 0);
      chk(rd & 32'hc0, 32'h80);
      bus(0, IDX_RESULT, 0);
      chk(rd, {22'h0, 3'(ch), 7'h35});
      bus(0, IDX_STATE, 0);
      chk(rd & 32'h80, 32'h0);
      bus(0, IDX_CTRL_ONE, 0);
      chk(rd, 32'h20 | 32'(ch));
      chk(32'(lad), 32'(ch == 5));
      bus(1, IDX_IRQ_STAT, 32'h1);
      idle(2);
      chk(32'(irq), 32'h0);
    end
  endtask
  // Off, reserved mode, reserved channel and a zero start must not launch; halfword writes are dropped
  task automatic t_refuse();
    logic [7:0] cmd [4] = '{8'h83, 8'hc3, 8'ha9, 8'h21};
    bus(1, IDX_CTRL_TWO, 0);
    hsize <= 3'h1;
    bus(1, IDX_CTRL_TWO, 32'h20);
    hsize <= 3'h2;
    bus(0, IDX_CTRL_TWO, 0);
    chk(rd, 32'h10);
    foreach (cmd[i]) begin
      bus(1, IDX_CTRL_ONE, {24'h0, cmd[i]});
      idle(6);
      chk(32'(sh), 32'h0);
      bus(0, IDX_CTRL_ONE, 0);
      chk(rd, {24'h0, cmd[i] & 8'h7f});
    end
  endtask
  // Repeat mode relaunches alone; masked status holds the line low
  task automatic t_repeat();
    int n = 0;
    bus(1, IDX_IRQ_MASK, 0);
    bus(1, IDX_CTRL_ONE, 32'he4);
    do begin bus(0, IDX_IRQ_STAT, 0); n++; end while (rd[0] !== 1'b1 && n < 100);
    if (rd[0] !== 1'b1) hang();
    chk(32'(irq), 32'h0);
    bus(1, IDX_IRQ_MASK, 32'h1);
    idle(2);
    chk(32'(irq), 32'h1);
    bus(1, IDX_IRQ_STAT, 32'h1);
    wait_irq(n);
    bus(0, IDX_RESULT, 0);
    chk(rd, {22'h0, 3'h4, 7'h35});
    // Leaving repeat with no channel in use, so the inputs are gated off
    bus(1, IDX_CTRL_ONE, 32'h14);
    idle(60);
    chk(32'(gate), 32'h1);
    n = 0;
    repeat (60) begin @(posedge clock); n += sh; end
    chk(32'(n), 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_soft();
    t_refuse();
    t_repeat();
    test_done();
  end
endmodule // testbench
